// *** logic/ccd_map.svh ***
// Register offsets, field positions, reset values and counts of the caption capture block
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define CCD_OFS_MAIN_STATUS 8'h00
`define CCD_OFS_CAP_STATUS 8'h1c
`define CCD_OFS_CAP_DATA 8'h1d
`define CCD_OFS_EVT_STATUS 8'h20
`define CCD_OFS_EVT_CLEAR 8'h21
`define CCD_OFS_EVT_ENABLE 8'h22

// ****************************************
// Field positions
// ****************************************
`define CCD_MS_VALID 0
`define CCD_CS_CC_EN 0
`define CCD_CS_EDS_EN 1
`define CCD_CS_IRQ_EN 2
`define CCD_CS_DAV 3
`define CCD_CS_OVF 4
`define CCD_CS_HALF 5
`define CCD_CS_KIND 6
`define CCD_CS_PERR 7
`define CCD_EV_HALF 0
`define CCD_EV_OVF 1
`define CCD_EV_PERR 2

// ****************************************
// Reset values and counts
// ****************************************
`define CCD_RST_CTRL 3'h0
`define CCD_RST_EVT_EN 3'h0
`define CCD_SLICE_LVL 8'h50
`define CCD_RUNIN_MIN 4'h6
`define CCD_START_CODE 3'h1
`define CCD_BYTE_BITS 4'h8
`define CCD_FIFO_HALF 5'h08
`define CCD_FIFO_DEPTH 5'h10

`endif

// *** logic/ccd_pkg.sv ***
// Types shared by the caption capture block
package ccd_pkg;

	typedef enum logic [1:0] {
		CCD_IDLE = 2'b00,
		CCD_RUNIN = 2'b01,
		CCD_START = 2'b10,
		CCD_DATA = 2'b11
	} ccd_fsm_t;

	// One FIFO entry: ten bits
	typedef struct packed {
		logic kind;
		logic half;
		logic [7:0] data;
	} ccd_entry_t;

	typedef struct packed {
		ccd_entry_t [15:0] mem;
		logic [3:0] wp;
		logic [3:0] rp;
		logic [4:0] cnt;
	} ccd_fifo_st_t;

	typedef struct packed {
		ccd_fsm_t fsm;
		logic kind;
		logic prev_bit;
		logic [3:0] run_cnt;
		logic [2:0] code_sh;
		logic [3:0] bit_cnt;
		logic [7:0] byte_sh;
		logic cc_line_d;
		logic eds_line_d;
		logic cc_en;
		logic eds_en;
		logic irq_en;
		logic ovf;
		logic half_d;
		logic [2:0] evt;
		logic [2:0] evt_en;
		logic [7:0] rdata;
		logic irq;
	} ccd_st_t;

endpackage

// *** logic/ccd_fifo.sv ***
// Sixteen by ten entry caption FIFO with read priority and flush
module ccd_fifo
	import ccd_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic flush_in,
	input wire logic push_in,
	input ccd_entry_t wr_entry_in,
	input wire logic pop_in,
	output ccd_entry_t head_out,
	output logic [4:0] cnt_out,
	output logic full_out,
	output logic empty_out,
	output logic half_out
);
`include "ccd_map.svh"

	// sixteen ten-bit entries held in flip-flops
	ccd_fifo_st_t st_r;
	ccd_fifo_st_t st_nxt;
	logic do_pop;
	logic do_push;

	always_comb begin
		full_out = (st_r.cnt == `CCD_FIFO_DEPTH);
		empty_out = (st_r.cnt == 5'h00);
		half_out = (st_r.cnt >= `CCD_FIFO_HALF);
		cnt_out = st_r.cnt;
		head_out = st_r.mem[st_r.rp];
	end

	always_comb begin
		st_nxt = st_r;
		do_pop = pop_in && !empty_out;
		// a full FIFO serves the read, the write is lost
		do_push = push_in && !full_out;
		if (flush_in) begin
			st_nxt.wp = 4'h0;
			st_nxt.rp = 4'h0;
			st_nxt.cnt = 5'h00;
		end else begin
			if (do_push) begin
				st_nxt.mem[st_r.wp] = wr_entry_in;
				st_nxt.wp = st_r.wp + 4'h1;
			end
			if (do_pop) begin
				st_nxt.rp = st_r.rp + 4'h1;
			end
			if (do_push && !do_pop) begin
				st_nxt.cnt = st_r.cnt + 5'h01;
			end else if (do_pop && !do_push) begin
				st_nxt.cnt = st_r.cnt - 5'h01;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!nrst_in);

	read_priority_a: assert property (
		(full_out && push_in && pop_in && !flush_in) |=> (cnt_out == 5'h0f))
		else $error("read did not win over write on a full FIFO");
	depth_bound_a: assert property (
		cnt_out <= `CCD_FIFO_DEPTH)
		else $error("FIFO count above sixteen");

endmodule

// *** logic/ccd_capture.sv ***
// Caption and extended-data byte capture with FIFO and register port
// How it works
// - Caption and extended capture each have an enable bit in the status register.
// - Search for clock run-in, then start code 001, before capturing data.
// - Each byte is seven data bits plus parity, checked for odd parity.
// - Captured bytes go into a sixteen entry, ten bit wide FIFO.
// - Low byte first, then high byte, each written only when FIFO not full.
// - Each entry tags caption/extended and low/high, readable in caption status.
// - Parity bit stored in the entry; check result shown as parity error.
// - Data available low while empty, high once an entry is stored.
// - Half full drives the caption interrupt when both the status interrupt enable and its event enable bit are set.
// - Main status caption valid flag mirrors FIFO half full for polling.
// - Oldest entry shows in data and status; each data read advances.
// - A byte arriving while the FIFO is full is lost and sets overflow.
// - Host clears overflow by reading data; the device then drops the flag.
// - Reads and writes may coincide; the read takes priority.
// - A clearing read coinciding with a write leaves overflow set.
// - Clearing both enables flushes the FIFO and loses all entries.
// - Slicing works on the separated luma samples only.
//
// Design decision made here: strobed register access.
module ccd_capture
	import ccd_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic [7:0] luma_in,
	input wire logic bit_stb_in,
	input wire logic cc_line_in,
	input wire logic eds_line_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	output logic caption_half_full_irq_out
);
`include "ccd_map.svh"

	ccd_st_t st_r;
	ccd_st_t st_nxt;
	ccd_entry_t head;
	ccd_entry_t wr_entry;
	logic [4:0] fifo_cnt;
	logic fifo_full;
	logic fifo_empty;
	logic fifo_half;
	logic sliced_bit;
	logic byte_done;
	logic push_try;
	logic pop_req;
	logic flush;
	logic [7:0] cap_status;
	logic [7:0] main_status;

	// ****************************************
	// Decoding helpers
	// ****************************************
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	// Odd parity holds when the ones count of all eight bits is odd
	function automatic logic parity_bad(input logic [7:0] b);
		parity_bad = ~(^b);
	endfunction

	// ****************************************
	// FIFO
	// ****************************************
	// one clock serves writer and reader, so the flags never tear
	ccd_fifo u_fifo (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.flush_in(flush),
		.push_in(push_try),
		.wr_entry_in(wr_entry),
		.pop_in(pop_req),
		.head_out(head),
		.cnt_out(fifo_cnt),
		.full_out(fifo_full),
		.empty_out(fifo_empty),
		.half_out(fifo_half)
	);

	// ****************************************
	// Combinational views
	// ****************************************
	always_comb begin
		// luma sample sliced at a fixed level
		sliced_bit = (luma_in >= `CCD_SLICE_LVL);
		byte_done = (st_r.fsm == CCD_DATA) && bit_stb_in &&
			(st_r.bit_cnt[2:0] == 3'h7);
		// low byte completes at bit 8, high byte at bit 16
		push_try = byte_done;
		wr_entry.kind = st_r.kind;
		wr_entry.half = st_r.bit_cnt[3];
		// seven character bits and parity in the top bit
		wr_entry.data = {sliced_bit, st_r.byte_sh[7:1]};
		pop_req = reg_rd_in && hit(reg_addr_in, `CCD_OFS_CAP_DATA);
		// no capture enabled empties the FIFO
		flush = !st_r.cc_en && !st_r.eds_en;
		cap_status = 8'h00;
		cap_status[`CCD_CS_CC_EN] = st_r.cc_en;
		cap_status[`CCD_CS_EDS_EN] = st_r.eds_en;
		cap_status[`CCD_CS_IRQ_EN] = st_r.irq_en;
		cap_status[`CCD_CS_DAV] = !fifo_empty;
		cap_status[`CCD_CS_OVF] = st_r.ovf;
		cap_status[`CCD_CS_HALF] = head.half;
		cap_status[`CCD_CS_KIND] = head.kind;
		// parity check result of the oldest entry
		cap_status[`CCD_CS_PERR] = !fifo_empty && parity_bad(head.data);
		main_status = 8'h00;
		main_status[`CCD_MS_VALID] = fifo_half;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic [2:0] evt_set;
		logic [2:0] evt_clr;
		logic arm_cc;
		logic arm_eds;
		evt_set = 3'h0;
		evt_clr = 3'h0;
		arm_cc = 1'b0;
		arm_eds = 1'b0;
		st_nxt = st_r;
		st_nxt.cc_line_d = cc_line_in;
		st_nxt.eds_line_d = eds_line_in;
		st_nxt.half_d = fifo_half;

		// arm at the start of the caption or extended line
		// only lines whose capture is enabled are armed
		arm_cc = cc_line_in && !st_r.cc_line_d && st_r.cc_en;
		arm_eds = eds_line_in && !st_r.eds_line_d && st_r.eds_en;

		case (st_r.fsm)
			CCD_IDLE: begin
				if (arm_cc || arm_eds) begin
					st_nxt.fsm = CCD_RUNIN;
					st_nxt.kind = arm_eds;
					st_nxt.run_cnt = 4'h0;
					st_nxt.code_sh = 3'h7;
					st_nxt.bit_cnt = 4'h0;
				end
			end
			CCD_RUNIN: begin
				if (bit_stb_in) begin
					st_nxt.prev_bit = sliced_bit;
					if (sliced_bit != st_r.prev_bit) begin
						st_nxt.run_cnt = st_r.run_cnt + 4'h1;
					end else begin
						st_nxt.run_cnt = 4'h0;
					end
					st_nxt.code_sh = {st_r.code_sh[1:0], sliced_bit};
					if (st_r.run_cnt >= `CCD_RUNIN_MIN) begin
						st_nxt.fsm = CCD_START;
					end
				end
			end
			CCD_START: begin
				// wait for start code after the run-in
				if (bit_stb_in) begin
					st_nxt.code_sh = {st_r.code_sh[1:0], sliced_bit};
					if ({st_r.code_sh[1:0], sliced_bit} == `CCD_START_CODE) begin
						st_nxt.fsm = CCD_DATA;
						st_nxt.bit_cnt = 4'h0;
					end
				end
			end
			CCD_DATA: begin
				// Bits arrive least significant first
				if (bit_stb_in) begin
					st_nxt.byte_sh = {sliced_bit, st_r.byte_sh[7:1]};
					st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
					if (st_r.bit_cnt == 4'hf) begin
						st_nxt.fsm = CCD_IDLE;
					end
				end
			end
			default: begin
				st_nxt.fsm = CCD_IDLE;
			end
		endcase

		// Leaving the line abandons a search in progress
		if (st_r.fsm != CCD_IDLE) begin
			if ((st_r.kind && !eds_line_in) || (!st_r.kind && !cc_line_in)) begin
				st_nxt.fsm = CCD_IDLE;
			end
		end

		// ****************************************
		// Overflow
		// ****************************************
		// a data read with no write attempt drops overflow
		// a read coinciding with a write attempt keeps it
		if (pop_req && !push_try) begin
			st_nxt.ovf = 1'b0;
		end
		// byte lost on a full FIFO sets overflow; the flush clear below wins over the set
		if (push_try && fifo_full) begin
			st_nxt.ovf = 1'b1;
			evt_set[`CCD_EV_OVF] = 1'b1;
		end
		if (flush) begin
			st_nxt.ovf = 1'b0;
		end

		if (push_try && !fifo_full && parity_bad(wr_entry.data)) begin
			evt_set[`CCD_EV_PERR] = 1'b1;
		end
		if (fifo_half && !st_r.half_d) begin
			evt_set[`CCD_EV_HALF] = 1'b1;
		end

		// ****************************************
		// Register writes and reads
		// ****************************************
		if (reg_wr_in) begin
			if (hit(reg_addr_in, `CCD_OFS_CAP_STATUS)) begin
				st_nxt.cc_en = reg_wdata_in[`CCD_CS_CC_EN];
				st_nxt.eds_en = reg_wdata_in[`CCD_CS_EDS_EN];
				st_nxt.irq_en = reg_wdata_in[`CCD_CS_IRQ_EN];
			end
			if (hit(reg_addr_in, `CCD_OFS_EVT_CLEAR)) begin
				evt_clr = reg_wdata_in[2:0];
			end
			if (hit(reg_addr_in, `CCD_OFS_EVT_ENABLE)) begin
				st_nxt.evt_en = reg_wdata_in[2:0];
			end
		end
		for (int i = 0; i < 3; i++) begin
			st_nxt.evt[i] = evt_set[i] || (st_r.evt[i] && !evt_clr[i]);
		end

		st_nxt.rdata = 8'h00;
		if (reg_rd_in) begin
			case (reg_addr_in)
				`CCD_OFS_MAIN_STATUS: begin
					st_nxt.rdata = main_status;
				end
				`CCD_OFS_CAP_STATUS: begin
					st_nxt.rdata = cap_status;
				end
				`CCD_OFS_CAP_DATA: begin
					// head entry, then the FIFO advances
					st_nxt.rdata = head.data;
				end
				`CCD_OFS_EVT_STATUS: begin
					st_nxt.rdata = {5'h00, st_r.evt};
				end
				`CCD_OFS_EVT_ENABLE: begin
					st_nxt.rdata = {5'h00, st_r.evt_en};
				end
				default: begin
					st_nxt.rdata = 8'h00;
				end
			endcase
		end

		// half-full event reaches the pin only with its enable bit
		st_nxt.irq = (st_r.evt[`CCD_EV_HALF] && st_r.evt_en[`CCD_EV_HALF] && st_r.irq_en) ||
			(st_r.evt[`CCD_EV_OVF] && st_r.evt_en[`CCD_EV_OVF]) ||
			(st_r.evt[`CCD_EV_PERR] && st_r.evt_en[`CCD_EV_PERR]);
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_r <= '0;
			st_r.fsm <= CCD_IDLE;
			st_r.cc_en <= 1'(`CCD_RST_CTRL >> `CCD_CS_CC_EN);
			st_r.eds_en <= 1'(`CCD_RST_CTRL >> `CCD_CS_EDS_EN);
			st_r.irq_en <= 1'(`CCD_RST_CTRL >> `CCD_CS_IRQ_EN);
			st_r.evt_en <= `CCD_RST_EVT_EN;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_comb begin
		reg_rdata_out = st_r.rdata;
		caption_half_full_irq_out = st_r.irq;
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!nrst_in);

	sequence s_code_seen;
		(st_r.fsm == CCD_START) && bit_stb_in &&
			({st_r.code_sh[1:0], sliced_bit} == `CCD_START_CODE);
	endsequence

	sequence s_still_on_line;
		(st_r.kind ? eds_line_in : cc_line_in);
	endsequence

	start_code_a: assert property (
		(s_code_seen and s_still_on_line) |=> (st_r.fsm == CCD_DATA) && (st_r.bit_cnt == 4'h0))
		else $error("start code did not begin data capture");
	overflow_set_a: assert property (
		(push_try && fifo_full && !flush) |=> st_r.ovf && (fifo_cnt == $past(fifo_cnt) - {4'h0, $past(pop_req)}))
		else $error("overflow not flagged on a full write");
	overflow_keep_a: assert property (
		(st_r.ovf && pop_req && push_try && !flush) |=> st_r.ovf)
		else $error("coinciding read cleared overflow");
	overflow_clear_a: assert property (
		(st_r.ovf && pop_req && !push_try) |=> !st_r.ovf)
		else $error("data read did not clear overflow");
	flush_empty_a: assert property (
		(!st_r.cc_en && !st_r.eds_en) |=> fifo_empty)
		else $error("FIFO not flushed with both enables low");
	data_read_a: assert property (
		(pop_req && !fifo_empty) |=> (reg_rdata_out == $past(head.data)) ##1
			($past(reg_rd_in) || (reg_rdata_out == 8'h00))[*1])
		else $error("data read returned the wrong entry");
	dav_flag_a: assert property (
		(reg_rd_in && hit(reg_addr_in, `CCD_OFS_CAP_STATUS)) |=>
			(reg_rdata_out[`CCD_CS_DAV] == !$past(fifo_empty)))
		else $error("data available flag wrong");
	valid_mirror_a: assert property (
		(reg_rd_in && hit(reg_addr_in, `CCD_OFS_MAIN_STATUS)) |=>
			(reg_rdata_out[`CCD_MS_VALID] == ($past(fifo_cnt) >= `CCD_FIFO_HALF)))
		else $error("caption valid does not mirror half full");
	irq_gate_a: assert property (
		(st_r.evt[`CCD_EV_HALF] && st_r.evt_en[`CCD_EV_HALF] && st_r.irq_en) |=>
			caption_half_full_irq_out)
		else $error("enabled half-full event did not raise the pin");
	byte_order_a: assert property (
		(push_try && st_r.bit_cnt == 4'h7) |-> (wr_entry.half == 1'b0))
		else $error("first byte not tagged low");

endmodule

// *** tb/ccd_line_src.sv ***
// Behavioural caption line source driving the slicer inputs
module ccd_line_src (
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic kind_in,
	input wire logic bad_in,
	input wire logic [3:0] gap_in,
	input wire logic [15:0] word_in,
	output logic [7:0] luma_out,
	output logic stb_out,
	output logic cc_line_out,
	output logic eds_line_out,
	output logic busy_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [25:0] seq;
	initial begin
		luma_out = 8'h00;
		stb_out = 1'b0;
		cc_line_out = 1'b0;
		eds_line_out = 1'b0;
		busy_out = 1'b0;
	end
	always @(posedge clk_in) begin
		if (go_in) begin
			seq = {word_in, 3'b100, 7'b1010101} ^ (26'(bad_in) << 3);
			busy_out <= 1'b1;
			cc_line_out <= ~kind_in;
			eds_line_out <= kind_in;
			for (int i = 0; i < 26; i++) begin
				// Luma toggles between strobes so stale levels never match
				repeat (gap_in) begin
					luma_out <= ~luma_out;
					@(posedge clk_in);
				end
				stb_out <= 1'b1;
				luma_out <= seq[i] ? 8'h50 : 8'h4f;
				@(posedge clk_in);
				stb_out <= 1'b0;
			end
			repeat (2) @(posedge clk_in);
			cc_line_out <= 1'b0;
			eds_line_out <= 1'b0;
			busy_out <= 1'b0;
		end
	end
endmodule

// *** tb/tb_ccd_capture.sv ***
// Self-checking bench for the caption capture block
module tb_ccd_capture;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic go = 1'b0;
	logic kind = 1'b0;
	logic bad = 1'b0;
	logic [3:0] gap = 4'h1;
	logic [15:0] word = 16'h0000;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] luma, rdata;
	logic stb, cc_ln, eds_ln, busy, irq;
	logic [2:0] ctl = 3'h0;
	logic [2:0] evt = 3'h0;
	logic ovf = 1'b0;
	logic [10:0] q[$];
	int mismatches = 0;
	int checks = 0;
	int seed;

	always #4 sys_clk_in = ~sys_clk_in;

	ccd_capture i_dut (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.luma_in(luma),
		.bit_stb_in(stb),
		.cc_line_in(cc_ln),
		.eds_line_in(eds_ln),
		.reg_addr_in(addr),
		.reg_wdata_in(wdata),
		.reg_wr_in(wr),
		.reg_rd_in(rd),
		.reg_rdata_out(rdata),
		.caption_half_full_irq_out(irq)
	);
	ccd_line_src i_src (.clk_in(sys_clk_in), .go_in(go), .kind_in(kind), .bad_in(bad),
		.gap_in(gap), .word_in(word), .luma_out(luma), .stb_out(stb),
		.cc_line_out(cc_ln), .eds_line_out(eds_ln), .busy_out(busy));

	// ********
	// Tasks
	// ********
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk_in);
		wr <= 1'b0;
		// One idle edge so a following write never re-raises the strobe at once
		@(posedge sys_clk_in);
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk_in);
		rd <= 1'b0;
		// Read data stand only in the cycle after the strobe
		@(posedge sys_clk_in);
		d = rdata;
	endtask

	// Head tags are undefined while empty, so they are masked then
	task automatic cmp_state();
		logic [7:0] d;
		logic [7:0] m;
		m = (q.size() != 0) ? 8'hff : 8'h9f;
		reg_rd(8'h1c, d);
		check(d & m, {q.size() != 0 ? q[0][10:8] : 3'h0, ovf, q.size() != 0, ctl});
		reg_rd(8'h00, d);
		check({7'h00, d[0]}, {7'h00, q.size() >= 8});
		reg_rd(8'h20, d);
		check(d, {5'h00, evt});
		check({7'h00, irq}, {7'h00, (evt[0] & ctl[2]) | evt[1] | evt[2]});
	endtask

	// A nonzero cut reads the data register beside the low byte's write
	task automatic send_line(input logic k, input logic [15:0] w, input logic b, input int cut);
		int n;
		int sc;
		int rs;
		logic [7:0] byt;
		kind <= k;
		word <= w;
		bad <= b;
		// Strobes two cycles apart let the coinciding read land exactly
		gap <= (cut != 0) ? 4'h1 : 4'(1 + $unsigned($random(seed)) % 4);
		go <= 1'b1;
		@(posedge sys_clk_in);
		go <= 1'b0;
		n = 0;
		sc = 0;
		rs = 0;
		do begin
			@(posedge sys_clk_in);
			n++;
			if (rs == 1) begin
				rd <= 1'b1;
				addr <= 8'h1d;
				rs = 2;
			end else if (rs == 2) begin
				rd <= 1'b0;
				rs = 3;
			end else if (rs == 3) begin
				check(rdata, q[0][7:0]);
				void'(q.pop_front());
				rs = 0;
			end
			if (stb === 1'b1) begin
				sc++;
				if (cut != 0 && sc == cut) begin
					rs = 1;
				end
			end
		end while (busy !== 1'b0 && n < 2000);
		if (n >= 2000) begin
			mismatches++;
			print_verdict();
		end
		if (!b && ctl[k]) begin
			for (int h = 0; h < 2; h++) begin
				byt = w[8*h +: 8];
				// Read priority: the low byte meets a full FIFO and is lost
				if (q.size() >= 16 || (cut != 0 && h == 0)) begin
					ovf = 1'b1;
					evt[1] = 1'b1;
				end else begin
					q.push_back({~^byt, k, h[0], byt});
					evt[0] = evt[0] | (q.size() == 8);
					evt[2] = evt[2] | ~^byt;
				end
			end
		end
		repeat (2) @(posedge sys_clk_in);
	endtask

	// ********
	// Main sequence
	// ********
	initial begin
		logic [7:0] d;
		seed = 32'hc535;
		repeat (2) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		@(posedge sys_clk_in);
		cmp_state();
		reg_wr(8'h55, 8'hff);
		reg_rd(8'h55, d);
		check(d, 8'h00);
		reg_wr(8'h22, 8'h07);
		// Extended capture only; read-only bits must ignore the ones
		reg_wr(8'h1c, 8'hfa);
		ctl = 3'h2;
		send_line(1'b0, 16'h8001, 1'b0, 0);
		cmp_state();
		reg_wr(8'h1c, 8'h07);
		ctl = 3'h7;
		send_line(1'b0, 16'h0000, 1'b1, 0);
		cmp_state();
		// Nine lines overrun the sixteen entries by two bytes
		repeat (9) begin
			send_line(1'($random(seed)), 16'($random(seed)), 1'b0, 0);
			cmp_state();
		end
		reg_wr(8'h22, 8'h00);
		@(posedge sys_clk_in);
		@(negedge sys_clk_in);
		check({7'h00, irq}, 8'h00);
		reg_wr(8'h22, 8'h07);
		// Read beside the low byte's write on a full FIFO: overflow must stay
		send_line(1'b0, 16'($random(seed)), 1'b0, 17);
		cmp_state();
		while (q.size() != 0) begin
			reg_rd(8'h1d, d);
			check(d, q[0][7:0]);
			void'(q.pop_front());
			ovf = 1'b0;
			cmp_state();
		end
		reg_wr(8'h21, 8'h07);
		evt = 3'h0;
		cmp_state();
		send_line(1'b1, 16'($random(seed)), 1'b0, 0);
		cmp_state();
		reg_wr(8'h1c, 8'h04);
		ctl = 3'h4;
		q.delete();
		cmp_state();
		reg_wr(8'h1c, 8'h01);
		ctl = 3'h1;
		send_line(1'b0, 16'h7f80, 1'b0, 0);
		cmp_state();
		reg_rd(8'h1d, d);
		check(d, 8'h80);
		print_verdict();
	end
endmodule
